// ### design/pin_if.sv
// Purpose: carries the synchronised reset pin level and its rising edge
// Assumes: both signals are in the ref_clk domain
// Notes: rise is a one-cycle pulse
`timescale 1ns/1ns

interface pin_if;
  logic level;
  logic rise;
  modport src (output level, output rise);
  modport dst (input level, input rise);
endinterface

// ### design/pin_sync.sv
// Purpose: two-flop synchroniser for the reset pin with edge pulse
// Assumes: pin is asynchronous to ref_clk
// Notes: first flop is read only by the second
`timescale 1ns/1ns

module pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Pin
  input wire logic pin_n,
  // Synchronised view
  pin_if.src sync
);

  logic meta_q;
  logic level_q;
  logic prev_q;

  // Edge taken from the settled level so the metastable flop has one reader
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      level_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_n;
      level_q <= meta_q;
      prev_q <= level_q;
    end
  end

  wire rise_w = level_q & ~prev_q;

  assign sync.level = level_q;
  assign sync.rise = rise_w;

endmodule

// ### design/rate_div.sv
// Purpose: sample-rate enable derived from the system clock
// Assumes: en high only while digital clocks run
// Notes: rate follows the supplied clock since the ratio is fixed
`timescale 1ns/1ns
`include "reset_seq_defs.svh"

module rate_div #(
  parameter int unsigned DIV = `SAMPLE_DIV
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Control
  input wire logic en,
  // Sample enable
  output logic tick
);

  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;

  generate
    if (DIV < 2) begin : g_bad
      $error("rate_div: DIV must be at least 2");
    end
  endgenerate

  logic [W-1:0] cnt_q;
  logic tick_q;
  wire last = (cnt_q == W'(DIV - 1));

  always_ff @(posedge ref_clk) begin
    if (!resetn || !en) begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= last ? '0 : cnt_q + W'(1);
      tick_q <= last;
    end
  end

  assign tick = tick_q;

endmodule

// ### design/reset_seq_defs.svh
// Purpose: timing figures, selection values and field positions
// Assumes: 25 MHz reference clock
// Notes: cycle counts are derived in the top module from these figures
`ifndef RESET_SEQ_DEFS_SVH
`define RESET_SEQ_DEFS_SVH

`define CLK_KHZ 25000
`define OSC_START_US 4000
`define WARM_WINDOW_US 50000
`define COLD_WINDOW_US 100000

`define SEL_COLD_TIMER 16'h0000
`define SEL_WARM_TIMER 16'h0006
`define SEL_COLD_NOW 16'h8000
`define SEL_WARM_NOW 16'h8006

`define REG_IDX_MSB 3
`define REG_IDX_LSB 1
`define SAMPLE_DIV 2560

`endif

// ### design/reset_seq_pkg.sv
// Purpose: types shared by the reset sequencer
// Assumes: reset_seq_defs.svh defines the selection values
// Notes: sel_decode is used for mode selection and for assertions
`include "reset_seq_defs.svh"

package reset_seq_pkg;

  typedef enum logic [2:0] {
    ST_OFF, ST_OSC, ST_CAL, ST_HOLD, ST_APPLY, ST_RUN
  } seq_state_type;

  typedef struct packed {
    logic hit;
    logic warm;
    logic now;
  } sel_type;

  function automatic sel_type sel_decode(input logic [15:0] word);
    sel_type s;
    s.hit = (word == `SEL_COLD_TIMER) || (word == `SEL_WARM_TIMER) ||
            (word == `SEL_COLD_NOW) || (word == `SEL_WARM_NOW);
    s.warm = (word == `SEL_WARM_TIMER) || (word == `SEL_WARM_NOW);
    s.now = (word == `SEL_COLD_NOW) || (word == `SEL_WARM_NOW);
    return s;
  endfunction

endpackage

// ### design/speakerphone_reset_sequencer.sv
// Purpose: reset, power-down and reset-mode sequencing of the device
// Assumes: host writes arrive as single-cycle strobes on ref_clk
// Notes: the reset pin is synchronised; times count from its rise
//
// How it works
// R01: Host holds reset pin low minimum time
// R02: Pin low powers down, stops oscillator
// R03: Pin rise enables oscillator, clocks after 4ms
// R04: Clocks running then calibrate and initialise
// R05: Selection write in warm window latches mode
// R06: No selection: cold reset at window end
// R07: Zero value selects cold reset at expiry
// R08: Value 0x0006 selects warm at expiry
// R09: Value 0x8000 starts cold reset immediately
// R10: Value 0x8006 starts warm reset immediately
// R11: Nonzero selections also stored as register writes
// R12: Host then rewrites the modified register
// R13: Cold reset clears converters, memories, registers
// R14: Warm reset keeps coefficients after cold once
// R15: Timer halts operation until bias settles
// R16: Sample rate scales with supplied clock
// R17: Late writes never alter the reset mode
`timescale 1ns/1ns
`include "reset_seq_defs.svh"

module speakerphone_reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter int unsigned OSC_CYC = `OSC_START_US * (`CLK_KHZ / 1000),
  parameter int unsigned WARM_CYC = `WARM_WINDOW_US * (`CLK_KHZ / 1000),
  parameter int unsigned COLD_CYC = `COLD_WINDOW_US * (`CLK_KHZ / 1000),
  parameter int unsigned SAMPLE_DIV = `SAMPLE_DIV
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // Hardware reset pin
  input wire logic rst_pin_n,
  // Host control word writes
  input wire logic host_wr_valid,
  input wire logic [15:0] host_wr_data,
  // Converter calibration
  input wire logic cal_done,
  output logic cal_start,
  // Power and clocks
  output logic powered_down,
  output logic osc_enable,
  output logic clk_run,
  output logic sample_tick,
  // Sequencing
  output logic halted,
  output logic cold_reset,
  output logic warm_reset,
  output logic coeff_clear,
  // Register writes toward the control registers
  output logic reg_wr_valid,
  output logic [2:0] reg_wr_index,
  output logic [15:0] reg_wr_data
);

  generate
    if (OSC_CYC < 1 || WARM_CYC > COLD_CYC || OSC_CYC > COLD_CYC)
    begin : g_bad
      $error("sequencer: need 1 <= OSC_CYC <= COLD_CYC, WARM <= COLD");
    end
  endgenerate

  pin_if pin_bus ();

  pin_sync u_pin_sync (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .pin_n(rst_pin_n),
    .sync(pin_bus)
  );

  seq_state_type st_q;
  seq_state_type st_d;
  logic [31:0] cnt_q;
  logic mode_warm_q;
  logic now_q;
  logic sel_seen_q;
  logic cold_seen_q;
  logic powered_down_q;
  logic osc_enable_q;
  logic clk_run_q;
  logic cal_start_q;
  logic halted_q;
  logic cold_reset_q;
  logic warm_reset_q;
  logic reg_wr_valid_q;
  logic [2:0] reg_wr_index_q;
  logic [15:0] reg_wr_data_q;

  // Decode and window terms
  wire pin_hi = pin_bus.level;
  wire osc_done = (cnt_q >= OSC_CYC);
  wire warm_open = (cnt_q < WARM_CYC);
  wire cold_end = (cnt_q >= COLD_CYC);
  wire sel_type sel = sel_decode(host_wr_data);
  wire sel_hit = host_wr_valid && pin_hi && warm_open && sel.hit &&
                 (st_q != ST_APPLY) && (st_q != ST_RUN);
  wire eff_warm = mode_warm_q && cold_seen_q;
  wire zero_sel = warm_open && (host_wr_data == `SEL_COLD_TIMER);
  wire fwd = host_wr_valid && pin_hi && !zero_sel;
  wire [2:0] fwd_idx = host_wr_data[`REG_IDX_MSB:`REG_IDX_LSB];

  // Sequence: oscillator start, calibration, timer hold, reset, run
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_OFF: begin
        if (pin_hi) begin
          st_d = ST_OSC; // R03
        end
      end
      ST_OSC: begin
        if (osc_done) begin
          st_d = ST_CAL; // R03
        end
      end
      ST_CAL: begin
        if (cal_done) begin
          st_d = ST_HOLD; // R04
        end
      end
      ST_HOLD: begin
        // Immediate selection skips the rest of the bias settling time
        if (now_q || cold_end) begin
          st_d = ST_APPLY; // R15
        end
      end
      ST_APPLY: st_d = ST_RUN;
      ST_RUN: st_d = ST_RUN;
      default: st_d = ST_OFF;
    endcase
    if (!pin_hi) begin
      st_d = ST_OFF; // R02
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      st_q <= ST_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  // Time since the pin rose; saturates once the cold window closes
  always_ff @(posedge ref_clk) begin
    if (!resetn || !pin_hi || pin_bus.rise) begin
      cnt_q <= '0;
    end else if (!cold_end) begin
      cnt_q <= cnt_q + 32'h1; // R03
    end
  end

  // Mode latch: the last valid selection inside the warm window before ST_APPLY wins
  always_ff @(posedge ref_clk) begin
    if (!resetn || !pin_hi) begin
      mode_warm_q <= 1'b0; // R07
      now_q <= 1'b0;
      sel_seen_q <= 1'b0;
    end else if (sel_hit) begin
      mode_warm_q <= sel.warm; // R05 R08
      now_q <= sel.now; // R09 R10
      sel_seen_q <= 1'b1;
    end
  end

  // Survives pin power-down; only a full reset forgets it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      cold_seen_q <= 1'b0;
    end else if (st_q == ST_APPLY && !eff_warm) begin
      cold_seen_q <= 1'b1; // R14
    end
  end

  // Outputs follow the next state so they line up with it
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      powered_down_q <= 1'b1;
      osc_enable_q <= 1'b0;
      clk_run_q <= 1'b0;
      cal_start_q <= 1'b0;
      halted_q <= 1'b1;
      cold_reset_q <= 1'b0;
      warm_reset_q <= 1'b0;
    end else begin
      powered_down_q <= (st_d == ST_OFF); // R02
      osc_enable_q <= (st_d != ST_OFF); // R02 R03
      clk_run_q <= (st_d != ST_OFF) && (st_d != ST_OSC); // R03
      cal_start_q <= (st_q == ST_OSC) && (st_d == ST_CAL); // R04
      halted_q <= (st_d != ST_RUN); // R15
      // Warm without an earlier cold would keep stale coefficients
      cold_reset_q <= (st_d == ST_APPLY) && !eff_warm; // R06 R07 R09 R13
      warm_reset_q <= (st_d == ST_APPLY) && eff_warm; // R08 R10 R14
    end
  end

  // Nonzero selection values double as ordinary register writes
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_wr_valid_q <= 1'b0;
      reg_wr_index_q <= 3'h0;
      reg_wr_data_q <= 16'h0000;
    end else begin
      reg_wr_valid_q <= fwd; // R11 R17
      if (fwd) begin
        reg_wr_index_q <= fwd_idx; // R11
        reg_wr_data_q <= host_wr_data;
      end
    end
  end

  rate_div #(
    .DIV(SAMPLE_DIV)
  ) u_rate_div (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .en(clk_run_q && !halted_q),
    .tick(sample_tick) // R16
  );

  assign powered_down = powered_down_q;
  assign osc_enable = osc_enable_q;
  assign clk_run = clk_run_q;
  assign cal_start = cal_start_q;
  assign halted = halted_q;
  assign cold_reset = cold_reset_q;
  assign warm_reset = warm_reset_q;
  assign coeff_clear = cold_reset_q; // R13
  assign reg_wr_valid = reg_wr_valid_q;
  assign reg_wr_index = reg_wr_index_q;
  assign reg_wr_data = reg_wr_data_q;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  pin_low_off_a: assert property ( // R02
    !pin_hi |=> powered_down && !osc_enable && !clk_run)
    else $error("pin low but device not powered down");

  clk_late_a: assert property ( // R03
    clk_run |-> cnt_q >= OSC_CYC || st_q == ST_RUN)
    else $error("clocks started before oscillator settled");

  cal_follow_a: assert property ( // R04
    $rose(clk_run) |-> cal_start)
    else $error("calibration not started with clocks");

  sel_latch_a: assert property ( // R05
    sel_hit |=> mode_warm_q == $past(sel.warm) && sel_seen_q)
    else $error("selection not latched");

  default_cold_a: assert property ( // R06
    st_q == ST_HOLD && !sel_seen_q && cold_end && pin_hi
    |=> cold_reset || !pin_hi)
    else $error("no default cold reset at window end");

  now_reset_a: assert property ( // R09 R10
    st_q == ST_HOLD && now_q && pin_hi
    |=> (cold_reset || warm_reset || !pin_hi))
    else $error("immediate selection did not reset");

  fwd_reg0_a: assert property ( // R11
    host_wr_valid && pin_hi && host_wr_data == `SEL_COLD_NOW
    |=> reg_wr_valid && reg_wr_index == 3'h0)
    else $error("selection not forwarded to register 0");

  late_keep_a: assert property ( // R17
    host_wr_valid && !warm_open && pin_hi
    |=> $stable(mode_warm_q) && $stable(now_q))
    else $error("late write changed reset mode");

  warm_prior_a: assert property ( // R14
    warm_reset |-> cold_seen_q && !coeff_clear)
    else $error("warm reset without earlier cold reset");

  halt_hold_a: assert property ( // R15
    st_q == ST_HOLD |=> halted && !sample_tick)
    else $error("operation resumed during reset timer");

endmodule

// ### tb/host_model.sv
// Purpose: host controller driving the reset pin and control word writes
// Assumes: called from the bench at falling clock edges
// Notes: an idle write bus shows the inverted last word, never a stale one
`timescale 1ns/1ns

module host_model #(
  parameter int MIN_LOW = 2
) (
  // Clock
  input wire logic ref_clk,
  // Toward the device
  output logic rst_pin_n,
  output logic host_wr_valid,
  output logic [15:0] host_wr_data
);
  initial begin
    rst_pin_n = 1'b0;
    host_wr_valid = 1'b0;
    host_wr_data = 16'hFFFF;
  end

  task automatic hold_low(input int n);
    @(negedge ref_clk);
    rst_pin_n = 1'b0;
    repeat ((n < MIN_LOW) ? MIN_LOW : n) @(negedge ref_clk);
  endtask

  task automatic release_pin();
    rst_pin_n = 1'b1;
  endtask

  task automatic write(input logic [15:0] w);
    host_wr_valid = 1'b1;
    host_wr_data = w;
    @(negedge ref_clk);
    host_wr_valid = 1'b0;
    host_wr_data = ~w;
  endtask
endmodule

// ### tb/tb_speakerphone_reset_sequencer.sv
// Purpose: self-checking bench for the reset sequencer
// Assumes: shortened counts 20, 200, 400 and 4
// Notes: times are measured from the pin rise in clock periods
`timescale 1ns/1ns

module tb_speakerphone_reset_sequencer;
  import reset_seq_pkg::*;
  localparam int OSC = 20;
  localparam int WARM = 200;
  localparam int COLD = 400;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cal_done = 1'b0;
  logic rst_pin_n, host_wr_valid, cal_start, powered_down, osc_enable;
  logic clk_run, sample_tick, halted, cold_reset, warm_reset, coeff_clear;
  logic reg_wr_valid;
  logic [2:0] reg_wr_index;
  logic [15:0] host_wr_data, reg_wr_data;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;
  time t0;

  initial forever #20 ref_clk = ~ref_clk;

  host_model i_host_model (.ref_clk(ref_clk), .rst_pin_n(rst_pin_n),
    .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data));

  speakerphone_reset_sequencer #(.OSC_CYC(OSC), .WARM_CYC(WARM),
    .COLD_CYC(COLD), .SAMPLE_DIV(4)) i_speakerphone_reset_sequencer (
    .ref_clk(ref_clk), .resetn(resetn), .rst_pin_n(rst_pin_n),
    .host_wr_valid(host_wr_valid), .host_wr_data(host_wr_data),
    .cal_done(cal_done), .cal_start(cal_start),
    .powered_down(powered_down), .osc_enable(osc_enable),
    .clk_run(clk_run), .sample_tick(sample_tick), .halted(halted),
    .cold_reset(cold_reset), .warm_reset(warm_reset),
    .coeff_clear(coeff_clear), .reg_wr_valid(reg_wr_valid),
    .reg_wr_index(reg_wr_index), .reg_wr_data(reg_wr_data));

  // Converter side: calibration finishes one cycle after it is started
  always @(negedge ref_clk) begin
    if (!rst_pin_n)
      cal_done <= 1'b0;
    else if (cal_start)
      cal_done <= 1'b1;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  function automatic int since();
    return int'(($time - t0) / 40);
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic run_seq(input logic wr, input logic [15:0] w,
                         input logic [2:0] idx, input logic ew,
                         input logic en);
    int k;
    int n;
    i_host_model.hold_low(4);
    chk(powered_down, 1'b1);
    chk(osc_enable, 1'b0);
    chk(clk_run, 1'b0);
    i_host_model.release_pin();
    t0 = $time;
    repeat (4) @(negedge ref_clk);
    chk(osc_enable, 1'b1);
    chk(powered_down, 1'b0);
    if (wr) begin
      i_host_model.write(w);
      chk(reg_wr_valid, w != 16'h0000);
      if (w != 16'h0000) begin
        chk(reg_wr_index, idx);
        chk(reg_wr_data, w);
      end
    end
    k = 0;
    while (clk_run !== 1'b1 && k < 100) begin
      @(negedge ref_clk);
      k++;
    end
    n = since();
    chk(n >= OSC && n <= OSC + 5, 1'b1);
    chk(cal_start, 1'b1);
    k = 0;
    while (cold_reset !== 1'b1 && warm_reset !== 1'b1 && k < 1000) begin
      @(negedge ref_clk);
      k++;
    end
    n = since();
    chk(warm_reset, ew);
    chk(cold_reset, !ew);
    chk(coeff_clear, !ew);
    chk(halted, 1'b1);
    if (en)
      chk(n < WARM, 1'b1);
    else
      chk(n >= COLD - 1 && n <= COLD + 6, 1'b1);
    @(negedge ref_clk);
    chk(halted, 1'b0);
  endtask

  task automatic s_cold_default();
    run_seq(1'b0, 16'h0000, 3'h0, 1'b0, 1'b0);
    $display("test cold_default done");
  endtask

  task automatic s_cold_timer();
    run_seq(1'b1, 16'h0000, 3'h0, 1'b0, 1'b0);
    $display("test cold_timer done");
  endtask

  task automatic s_warm_now();
    run_seq(1'b1, 16'h8006, 3'h3, 1'b1, 1'b1);
    $display("test warm_now done");
  endtask

  task automatic s_cold_now();
    run_seq(1'b1, 16'h8000, 3'h0, 1'b0, 1'b1);
    $display("test cold_now done");
  endtask

  // Timed warm reset, then a late rewrite that must not reselect a mode
  task automatic s_warm_timer_late();
    logic seen;
    time t1;
    run_seq(1'b1, 16'h0006, 3'h3, 1'b1, 1'b0);
    i_host_model.write(16'h8006);
    chk(reg_wr_valid, 1'b1);
    chk(reg_wr_index, 3'h3);
    chk(reg_wr_data, 16'h8006);
    seen = 1'b0;
    repeat (50) begin
      @(negedge ref_clk);
      seen = seen | cold_reset | warm_reset;
    end
    chk(seen, 1'b0);
    while (sample_tick !== 1'b1 && since() < 2000) @(negedge ref_clk);
    t1 = $time;
    @(negedge ref_clk);
    while (sample_tick !== 1'b1 && since() < 2000) @(negedge ref_clk);
    chk(16'(($time - t1) / 40), 16'h0004);
    $display("test warm_timer_late done");
  endtask

  // Full reset forgets the earlier cold reset, so a warm request runs cold
  task automatic s_warm_first();
    i_host_model.hold_low(2);
    resetn = 1'b0;
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    run_seq(1'b1, 16'h8006, 3'h3, 1'b0, 1'b1);
    $display("test warm_first done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge ref_clk);
    resetn = 1'b1;
    s_cold_default();
    s_cold_timer();
    s_warm_now();
    s_cold_now();
    s_warm_timer_late();
    s_warm_first();
    wrap_up();
  end
endmodule
